/* File: bench/mdsca_peer.sv */
module mdsca_peer
(
   input  wire logic pclk,
   input  wire logic en,
   input  wire logic kick,
   output logic      line
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] ph = 2'h0;
   // Plain always: the declaration initialiser would be a second driver under always_ff
   always @(posedge pclk)
      ph <= en ? ph + 2'h1 : 2'h0;
   // As master: low between one-cycle pulses; released line sits at pull-up level
   assign line = en ? (ph == 2'h0) : !kick;
endmodule : mdsca_peer

/* File: bench/mdsca_top_sva.sv */
module mdsca_top_chk
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic sync_pulse_out,
   input wire logic sync_clk_out
);
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence s_wait;
      psel && penable && !pready;
   endsequence
   a_clk_high: assert property ($rose(sync_clk_out) |-> sync_clk_out[*2])
      else $error("sync clock high too short");
   a_clk_low: assert property ($fell(sync_clk_out) |-> !sync_clk_out[*2])
      else $error("sync clock low too short");
   a_clk_stall: assert property (sync_clk_out[*4] |=> !sync_clk_out)
      else $error("sync clock held too long");
   a_pulse_gap: assert property (sync_pulse_out |=> !sync_pulse_out[*3])
      else $error("sync pulse too wide or too close");
   a_ready_wait: assert property (s_wait |=> pready)
      else $error("no answer one cycle after access");
   a_ready_once: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   a_ready_cause: assert property (pready |-> psel && penable && $past(penable))
      else $error("ready without access");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
endmodule : mdsca_top_chk

bind mdsca_top mdsca_top_chk u_chk (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
   .sync_pulse_out, .sync_clk_out);

/* File: bench/tb_multidevice_sync_clock_align.sv */
module tb_multidevice_sync_clock_align
   import mdsca_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic update_strobe = 1'b0;
   logic en = 1'b0;
   logic kick = 1'b0;
   logic line;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic sync_pulse_out;
   logic sync_clk_out;
   logic irq;
   logic [31:0] rd;
   logic er;
   logic [1:0] d;
   int n;
   int n_mismatch = 0;
   int cmp_count = 0;
   int cyc = 0;
   mdsca_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .sync_pulse_in(line), .update_strobe, .sync_pulse_out,
      .sync_clk_out, .irq);
   mdsca_peer peer (.pclk, .en, .kick, .line);
   always #20 pclk = !pclk;
   task automatic tally_and_finish();
      $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : tally_and_finish
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 6000)
      begin
         n_mismatch++;
         tally_and_finish();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   // Phase advance across a fixed window; 28 cycles, so zero unless stalled
   task automatic meas(input logic k, input logic s, output logic [1:0] dd);
      logic [1:0] p;
      apb(1'b0, MDSCA_STATE_OFF, 32'h0);
      p = rd[1:0];
      kick <= k;
      update_strobe <= s;
      repeat (8) @(posedge pclk);
      kick <= 1'b0;
      update_strobe <= 1'b0;
      repeat (16) @(posedge pclk);
      apb(1'b0, MDSCA_STATE_OFF, 32'h0);
      dd = rd[1:0] - p;
   endtask : meas
   task automatic pulses();
      n = 0;
      repeat (16)
      begin
         @(posedge pclk);
         n += int'(sync_pulse_out);
      end
   endtask : pulses
   initial
   begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, MDSCA_FC1_OFF, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, MDSCA_FC2_OFF, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 8'h20, 32'h0);
      chk(32'(er), 32'h1);
      apb(1'b1, MDSCA_FC2_OFF, 32'hC0);
      apb(1'b0, MDSCA_FC2_OFF, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, MDSCA_BUF2_OFF, 32'h0);
      chk(rd, 32'hC0);
      meas(1'b0, 1'b1, d);
      chk(32'(d), 32'h0);
      apb(1'b0, MDSCA_FC2_OFF, 32'h0);
      chk(rd, 32'hC0);
      pulses();
      chk(32'(n), 32'h4);
      apb(1'b1, MDSCA_IRQ_ST_OFF, 32'h2);
      apb(1'b0, MDSCA_IRQ_ST_OFF, 32'h0);
      chk(rd, 32'h0);
      // Slave facing a misaligned master
      apb(1'b1, MDSCA_IRQ_MK_OFF, 32'h1);
      apb(1'b1, MDSCA_FC2_OFF, 32'h80);
      en <= 1'b1;
      meas(1'b0, 1'b1, d);
      repeat (40) @(posedge pclk);
      chk(32'(irq), 32'h1);
      apb(1'b0, MDSCA_FC2_OFF, 32'h0);
      chk(rd, 32'hA0);
      apb(1'b0, MDSCA_FC2_OFF, 32'h0);
      chk(rd, 32'h80);
      apb(1'b1, MDSCA_IRQ_ST_OFF, 32'h1);
      chk(32'(irq), 32'h0);
      apb(1'b1, MDSCA_FC2_OFF, 32'h90);
      meas(1'b0, 1'b1, d);
      en <= 1'b0;
      repeat (5) @(posedge pclk);
      en <= 1'b1;
      repeat (40) @(posedge pclk);
      apb(1'b0, MDSCA_FC2_OFF, 32'h0);
      chk(rd, 32'h90);
      en <= 1'b0;
      apb(1'b1, MDSCA_FC2_OFF, 32'hC0);
      apb(1'b1, MDSCA_FC1_OFF, 32'h1);
      meas(1'b0, 1'b1, d);
      chk(32'(d), 32'h0);
      pulses();
      chk(32'(n), 32'h0);
      apb(1'b1, MDSCA_FC1_OFF, 32'h0);
      meas(1'b0, 1'b1, d);
      chk(32'(d), 32'h3);
      apb(1'b1, MDSCA_FC1_OFF, 32'h2);
      meas(1'b0, 1'b1, d);
      chk(32'(d), 32'h0);
      meas(1'b1, 1'b0, d);
      chk(32'(d), 32'h3);
      tally_and_finish();
   end
endmodule : tb_multidevice_sync_clock_align

/* File: hdl/mdsca_top.sv */
// Notes on behaviour
// R1 - Auto alignment runs only when enabled
// R2 - Master emits one-cycle pulse every four cycles
// R3 - Master bit low makes device a slave
// R4 - Slave stalls divider one cycle on mismatch
// R5 - Slave aligns within three sync periods
// R6 - Two-bit offset compensates pulse delay, resets 00
// R7 - Lost status sets on mismatch, clears on read
// R8 - Alignment runs regardless of mask; mask holds status low
// R9 - Update clearing soft bit stalls once
// R10 - With hard bit set, each sync input rising edge stalls once
// R11 - Each stall shifts phase one system period
// R12 - Manual modes leave sync output unused
// R13 - Controller repeats stalls until aligned
// R14 - Sync clock is system clock divided four
// R15 - Buffer copies to active on update
// R16 - Update strobe held over one sync period
// R17 - Update sampled on sync clock edge
// R18 - Controller delivers update coincidentally to all
// R19 - Strobe and sync input synchronised twice
module mdsca_top
   import mdsca_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        sync_pulse_in,
   input  wire logic        update_strobe,
   output logic             sync_pulse_out,
   output logic             sync_clk_out,
   output logic             irq
);

   typedef struct packed {
      logic [1:0]             sin_sync;
      logic [1:0]             upd_sync;
      logic                   sin_prev;
      logic                   upd_prev;
      logic [1:0]             phase;
      logic [7:0]             buf1;
      logic [7:0]             buf2;
      logic [7:0]             fc1;
      logic [7:0]             fc2;
      logic                   lost;
      logic [MDSCA_IRQ_W-1:0] irq_st;
      logic [MDSCA_IRQ_W-1:0] irq_mk;
      mdsca_upd_t             upd;
      logic [31:0]            prdata;
      logic                   pready;
      logic                   pslverr;
      logic                   pulse_out;
      logic                   sclk;
      logic                   irq;
   } mdsca_state_t;

   mdsca_state_t r;
   mdsca_state_t next_r;

   logic       sin_s;
   logic       upd_s;
   logic       sin_rise;
   logic       upd_rise;
   logic       auto_on;
   logic       master;
   logic       in_manual;
   logic [1:0] expect_phase;
   logic       stall;
   logic       mismatch;
   logic       soft_stall;
   logic       acc;
   logic       wr;
   logic       rd;
   logic       commit;

   always_comb
   begin
      next_r    = r;
      sin_s     = r.sin_sync[1];
      upd_s     = r.upd_sync[1];
      sin_rise  = sin_s & ~r.sin_prev;
      upd_rise  = upd_s & ~r.upd_prev;
      master    = r.fc2[MDSCA_MAST_BIT];
      in_manual = r.fc1[MDSCA_SOFT_BIT] | r.fc1[MDSCA_HARD_BIT];
      auto_on   = r.fc2[MDSCA_AUTO_BIT] & ~in_manual; // R1
      acc       = psel & penable & ~r.pready;
      wr        = acc & pwrite;
      rd        = acc & ~pwrite;
      commit    = 1'b0;
      soft_stall = 1'b0;

      // Two-stage synchronisers; first stage feeds only the second
      next_r.sin_sync = {r.sin_sync[0], sync_pulse_in}; // R19
      next_r.upd_sync = {r.upd_sync[0], update_strobe}; // R19
      next_r.sin_prev = sin_s;
      next_r.upd_prev = upd_s;

      // Update strobe seen on a sync clock rising edge, once per assertion
      case (r.upd)
         MDSCA_UPD_IDLE:
         begin
            if (upd_rise)
            begin
               next_r.upd = MDSCA_UPD_WAIT;
            end
         end
         MDSCA_UPD_WAIT:
         begin
            if (r.phase == MDSCA_PHASE_MAX) // R17
            begin
               commit     = 1'b1;
               next_r.upd = MDSCA_UPD_HELD;
            end
         end
         MDSCA_UPD_HELD:
         begin
            if (!upd_s)
            begin
               next_r.upd = MDSCA_UPD_IDLE;
            end
         end
         default:
         begin
            next_r.upd = MDSCA_UPD_IDLE;
         end
      endcase

      if (commit)
      begin
         // Buffered control becomes active only here
         next_r.fc1 = r.buf1; // R15
         next_r.fc2 = {r.buf2[7:6], r.fc2[MDSCA_LOST_BIT], r.buf2[4:0]}; // R15
         if (r.fc1[MDSCA_SOFT_BIT] && !r.buf1[MDSCA_SOFT_BIT])
         begin
            soft_stall = 1'b1; // R9
         end
      end

      // Slave compares divider phase with the delayed master pulse
      expect_phase = 2'(r.fc2[1:0] + 2'h1); // R6
      mismatch = auto_on & ~master & sin_rise & (r.phase != expect_phase); // R3 R4

      stall = soft_stall // R9
            | (r.fc1[MDSCA_HARD_BIT] & sin_rise) // R10
            | mismatch; // R4 R5

      // Divide-by-4; a stall holds the phase one cycle
      if (!stall)
      begin
         next_r.phase = 2'(r.phase + 2'h1); // R14 R11
      end
      next_r.sclk = (next_r.phase <= MDSCA_HIGH_LAST); // R14

      // Master pulse on phase 0, one cycle wide
      next_r.pulse_out = auto_on & master & (next_r.phase == 2'h0); // R2 R12

      // Lost status, held low by mask
      if (r.fc2[MDSCA_MASK_BIT])
      begin
         next_r.lost = 1'b0; // R8
      end
      else if (mismatch)
      begin
         next_r.lost = 1'b1; // R7
      end
      else if (rd && paddr == MDSCA_FC2_OFF)
      begin
         next_r.lost = 1'b0; // R7
      end

      // APB access, one wait state
      next_r.pready  = acc;
      next_r.pslverr = 1'b0;
      if (acc)
      begin
         next_r.prdata = 32'h0;
      end
      if (paddr == MDSCA_FC1_OFF)
      begin
         if (wr)
         begin
            next_r.buf1 = pwdata[7:0];
         end
         if (rd)
         begin
            next_r.prdata = {24'h0, r.fc1};
         end
      end
      else if (paddr == MDSCA_FC2_OFF)
      begin
         if (wr)
         begin
            next_r.buf2 = pwdata[7:0];
         end
         if (rd)
         begin
            next_r.prdata = {24'h0, r.fc2[7:6], r.lost, r.fc2[4:0]}; // R7
         end
      end
      else if (paddr == MDSCA_BUF1_OFF)
      begin
         if (rd)
         begin
            next_r.prdata = {24'h0, r.buf1};
         end
      end
      else if (paddr == MDSCA_BUF2_OFF)
      begin
         if (rd)
         begin
            next_r.prdata = {24'h0, r.buf2};
         end
      end
      else if (paddr == MDSCA_IRQ_ST_OFF)
      begin
         if (wr)
         begin
            next_r.irq_st = r.irq_st & ~pwdata[MDSCA_IRQ_W-1:0];
         end
         if (rd)
         begin
            next_r.prdata = {30'h0, r.irq_st};
         end
      end
      else if (paddr == MDSCA_IRQ_MK_OFF)
      begin
         if (wr)
         begin
            next_r.irq_mk = pwdata[MDSCA_IRQ_W-1:0];
         end
         if (rd)
         begin
            next_r.prdata = {30'h0, r.irq_mk};
         end
      end
      else if (paddr == MDSCA_STATE_OFF)
      begin
         if (rd)
         begin
            next_r.prdata = {28'h0, r.upd != MDSCA_UPD_IDLE, r.sclk, r.phase};
         end
      end
      else if (acc)
      begin
         next_r.pslverr = 1'b1;
      end

      // Events set after the clear so a coincident set wins
      if (mismatch)
      begin
         next_r.irq_st[MDSCA_IRQ_LOST] = 1'b1;
      end
      if (commit)
      begin
         next_r.irq_st[MDSCA_IRQ_UPD] = 1'b1;
      end
      next_r.irq = |(next_r.irq_st & next_r.irq_mk);
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         r        <= '0;
         r.fc1    <= MDSCA_FC1_RST;
         r.fc2    <= MDSCA_FC2_RST; // R6
         r.buf1   <= MDSCA_FC1_RST;
         r.buf2   <= MDSCA_FC2_RST;
         r.upd    <= MDSCA_UPD_IDLE;
         r.sclk   <= 1'b1;
         r.sin_sync <= 2'h3;
         r.sin_prev <= 1'b1;
      end
      else
      begin
         r <= next_r;
      end
   end

   assign prdata         = r.prdata;
   assign pready         = r.pready;
   assign pslverr        = r.pslverr;
   assign sync_pulse_out = r.pulse_out;
   assign sync_clk_out   = r.sclk;
   assign irq            = r.irq;

endmodule : mdsca_top

/* File: shared/mdsca_pkg.sv */
package mdsca_pkg;

   // APB register byte offsets
   localparam logic [7:0] MDSCA_FC1_OFF    = 8'h00;
   localparam logic [7:0] MDSCA_FC2_OFF    = 8'h04;
   localparam logic [7:0] MDSCA_BUF1_OFF   = 8'h08;
   localparam logic [7:0] MDSCA_BUF2_OFF   = 8'h0C;
   localparam logic [7:0] MDSCA_IRQ_ST_OFF = 8'h10;
   localparam logic [7:0] MDSCA_IRQ_MK_OFF = 8'h14;
   localparam logic [7:0] MDSCA_STATE_OFF  = 8'h18;

   // Field positions in function_control_one
   localparam int MDSCA_SOFT_BIT = 0;
   localparam int MDSCA_HARD_BIT = 1;
   // Field positions in function_control_two
   localparam int MDSCA_AUTO_BIT = 7;
   localparam int MDSCA_MAST_BIT = 6;
   localparam int MDSCA_LOST_BIT = 5;
   localparam int MDSCA_MASK_BIT = 4;
   localparam int MDSCA_OFS_LSB  = 0;

   // Reset values
   localparam logic [7:0] MDSCA_FC1_RST = 8'h00;
   localparam logic [7:0] MDSCA_FC2_RST = 8'h00;

   // Divider: sync clock is system clock divided by 4
   localparam int         MDSCA_DIV       = 4;
   localparam logic [1:0] MDSCA_PHASE_MAX = 2'(MDSCA_DIV - 1);
   // Sync clock high during phases 0..1
   localparam logic [1:0] MDSCA_HIGH_LAST = 2'h1;

   // Interrupt status bits
   localparam int MDSCA_IRQ_LOST = 0;
   localparam int MDSCA_IRQ_UPD  = 1;
   localparam int MDSCA_IRQ_W    = 2;

   typedef enum logic [2:0]
   {
      MDSCA_UPD_IDLE = 3'b001,
      MDSCA_UPD_WAIT = 3'b010,
      MDSCA_UPD_HELD = 3'b100
   } mdsca_upd_t;

endpackage : mdsca_pkg
